/* File: hdl/wwd_top.sv */
`timescale 1ns/1ps
`default_nettype none

// Operation
// - runs only in normal mode, clocked by base clock, not the bus clock
// - select bits 2..0 give window timeout 10 ms doubling to 1280 ms
// - inactive in low power; bus read during stop sets disabled flag
// - after release fixed initial timeout runs, open flag set, select ignored
// - initial phase: timeout or non-0xAA code resets; 0xAA enters window mode
// - window mode: first half closed, correct code accepted in second half
// - window mode: timeout or wrong code forces watchdog reset
// - config bit 6 reads whether window is open
// - test-disable input disables watchdog; config bit 7 reports it
// - disable resets service state; re-enable restarts initial sequence
// - low-power entry halts watchdog clock and resets service state
// - only expected code in open window clears; service writes ignored when disabled
// - config at 0x10 from 0x200 and 0x300; bits 5..3 zero; reset zero
module wwd_top #(
  parameter int P_MS_CYCLES = wwd_pkg::MS_CYCLES, // cycles per ms
  parameter int P_INIT_MS = wwd_pkg::INIT_TIMEOUT_MS // initial timeout
) (
  input wire logic i_clock, // base oscillator clock
  input wire logic i_rst, // async reset, active high
  input wire logic i_wr, // die-to-die write strobe
  input wire logic i_rd, // die-to-die read strobe
  input wire logic [wwd_pkg::ADDR_W-1:0] i_addr, // global address
  input wire logic [7:0] i_wdata, // write data
  input wire logic i_test_disable, // test disable voltage present
  input wire logic i_stop_mode, // device in stop mode
  input wire logic i_sleep_mode, // device in sleep mode
  output logic [7:0] o_rdata, // read data, held after a read
  output logic o_wd_reset_req, // watchdog reset request, held
  output logic o_window_open, // window open flag
  output logic o_wd_disabled // watchdog disabled flag
);

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic hit(input logic [wwd_pkg::ADDR_W-1:0] a,
                               input logic [wwd_pkg::ADDR_W-1:0] off);
    hit = (a == (wwd_pkg::BASE_BLOCKING + off)) ||
          (a == (wwd_pkg::BASE_NONBLOCKING + off));
  endfunction

  // code 110 falls on the doubling line as well
  function automatic logic [wwd_pkg::MS_CNT_W-1:0] win_ms(
      input logic [wwd_pkg::CFG_SEL_W-1:0] sel);
    win_ms = wwd_pkg::MS_CNT_W'(wwd_pkg::WIN_BASE_MS) << sel;
  endfunction

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    wwd_pkg::wwd_state_type state;
    logic [wwd_pkg::MS_CNT_W-1:0] ms_cnt;
    logic [wwd_pkg::CFG_SEL_W-1:0] sel;
    logic expect_first;
    logic stop_read;
    logic open;
    logic disabled;
    logic req;
    logic [7:0] rdata;
  } wwd_st_type;

  wwd_st_type q_r;
  wwd_st_type q_nxt;

  // unit step of the millisecond count, sized to it
  localparam logic [wwd_pkg::MS_CNT_W-1:0] MS_ONE =
    {{(wwd_pkg::MS_CNT_W-1){1'b0}}, 1'b1};

  logic low_power;
  logic active;
  logic tick;
  logic cfg_wr;
  logic cfg_rd;
  logic svc_wr;
  logic svc_ok;
  logic [wwd_pkg::MS_CNT_W-1:0] limit;
  logic win_open_now;
  logic restart;

  assign low_power = i_stop_mode | i_sleep_mode;
  // counting only in normal mode with no test disable
  assign active = !i_test_disable && !low_power;
  assign cfg_wr = i_wr && hit(i_addr, wwd_pkg::OFF_WATCHDOG_CONFIG);
  assign cfg_rd = i_rd && hit(i_addr, wwd_pkg::OFF_WATCHDOG_CONFIG);
  assign svc_wr = i_wr && hit(i_addr, wwd_pkg::OFF_WATCHDOG_SERVICE);
  assign svc_ok = q_r.expect_first ? (i_wdata == wwd_pkg::CODE_FIRST) :
                  (i_wdata == wwd_pkg::CODE_SECOND);
  assign limit = win_ms(q_r.sel);
  assign win_open_now = (q_r.ms_cnt >= (limit >> 1));
  // a counter clear also restarts the running millisecond
  assign restart = active && svc_wr &&
                   (q_r.state == wwd_pkg::ST_INIT ||
                    q_r.state == wwd_pkg::ST_WINDOW);

  // ----------------------------------------------------------------------
  // millisecond time base; stopped while inactive
  // ----------------------------------------------------------------------
  wwd_tick #(
    .P_MS_CYCLES(P_MS_CYCLES)
  ) u_tick (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_run(active),
    .i_restart(restart),
    .o_tick(tick)
  );

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    q_nxt = q_r;

    // stop-mode read flag: set wins over the clear by a normal read
    if (i_rd && i_stop_mode) begin
      q_nxt.stop_read = 1'b1;
    end else if (cfg_rd && active) begin
      q_nxt.stop_read = 1'b0;
    end

    if (cfg_wr) begin
      // select is stored in any phase; initial timeout does not use it
      q_nxt.sel = i_wdata[wwd_pkg::CFG_SEL_W-1:0];
    end

    case (q_r.state)
      wwd_pkg::ST_INIT: begin
        if (!active) begin
          q_nxt.state = wwd_pkg::ST_OFF;
        end else if (svc_wr) begin
          if (i_wdata == wwd_pkg::CODE_FIRST) begin
            q_nxt.state = wwd_pkg::ST_WINDOW;
            q_nxt.ms_cnt = '0;
            q_nxt.expect_first = 1'b0;
          end else begin
            q_nxt.state = wwd_pkg::ST_FAULT;
          end
        end else if (tick) begin
          if (q_r.ms_cnt == wwd_pkg::MS_CNT_W'(P_INIT_MS - 1)) begin
            q_nxt.state = wwd_pkg::ST_FAULT;
          end else begin
            q_nxt.ms_cnt = q_r.ms_cnt + MS_ONE;
          end
        end
      end
      wwd_pkg::ST_WINDOW: begin
        if (!active) begin
          q_nxt.state = wwd_pkg::ST_OFF;
        end else if (svc_wr) begin
          // a write in the closed half is treated as a wrong service
          if (svc_ok && win_open_now) begin
            q_nxt.ms_cnt = '0;
            q_nxt.expect_first = !q_r.expect_first;
          end else begin
            q_nxt.state = wwd_pkg::ST_FAULT;
          end
        end else if (tick) begin
          if (q_r.ms_cnt == limit - MS_ONE) begin
            q_nxt.state = wwd_pkg::ST_FAULT;
          end else begin
            q_nxt.ms_cnt = q_r.ms_cnt + MS_ONE;
          end
        end
      end
      wwd_pkg::ST_FAULT: begin
        // held until system reset; release restarts the initial phase
        q_nxt.req = 1'b1;
      end
      wwd_pkg::ST_OFF: begin
        // service state back to default; service writes have no effect here
        q_nxt.ms_cnt = '0;
        q_nxt.expect_first = 1'b1;
        if (active) begin
          q_nxt.state = wwd_pkg::ST_INIT;
        end
      end
      default: begin
        q_nxt.state = wwd_pkg::ST_OFF;
      end
    endcase

    if (q_nxt.state == wwd_pkg::ST_FAULT) begin
      q_nxt.req = 1'b1;
    end

    // open flag: always set in the initial phase
    case (q_nxt.state)
      wwd_pkg::ST_INIT: q_nxt.open = 1'b1;
      wwd_pkg::ST_WINDOW: q_nxt.open =
        (q_nxt.ms_cnt >= (win_ms(q_nxt.sel) >> 1));
      default: q_nxt.open = 1'b0;
    endcase

    q_nxt.disabled = i_test_disable || q_nxt.stop_read;

    // read port: config shows live flags, service is write-only
    if (cfg_rd) begin
      q_nxt.rdata = wwd_pkg::CFG_RESET;
      q_nxt.rdata[wwd_pkg::CFG_DISABLED_BIT] = q_r.disabled;
      q_nxt.rdata[wwd_pkg::CFG_WINDOW_OPEN_BIT] = q_r.open;
      q_nxt.rdata[wwd_pkg::CFG_SEL_W-1:0] = q_r.sel;
    end else if (i_rd) begin
      q_nxt.rdata = 8'h00;
    end
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      q_r.state <= wwd_pkg::ST_OFF;
      q_r.ms_cnt <= '0;
      q_r.sel <= wwd_pkg::SEL_RESET;
      q_r.expect_first <= 1'b1;
      q_r.stop_read <= 1'b0;
      q_r.open <= 1'b0;
      q_r.disabled <= 1'b0;
      q_r.req <= 1'b0;
      q_r.rdata <= 8'h00;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign o_rdata = q_r.rdata;
  assign o_wd_reset_req = q_r.req;
  assign o_window_open = q_r.open;
  assign o_wd_disabled = q_r.disabled;

endmodule

`default_nettype wire

/* File: hdl/wwd_pkg.sv */
package wwd_pkg;

  // ----------------------------------------------------------------------
  // clock and time base
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int MS_NS = 1000000;
  // cycles per millisecond tick, rounded down so a tick never runs long
  localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
  // window timeout for select code 000, doubled per code step
  localparam int WIN_BASE_MS = 10;
  // initial timeout after release; value is a plain default, trimmable
  localparam int INIT_TIMEOUT_MS = 256;
  localparam int MS_CNT_W = 16;

  // ----------------------------------------------------------------------
  // register map (global addresses of the die-to-die bus)
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] BASE_BLOCKING = 12'h200;
  localparam logic [ADDR_W-1:0] BASE_NONBLOCKING = 12'h300;
  localparam logic [ADDR_W-1:0] OFF_WATCHDOG_CONFIG = 12'h010;
  localparam logic [ADDR_W-1:0] OFF_WATCHDOG_SERVICE = 12'h011;

  // ----------------------------------------------------------------------
  // watchdog_config fields and reset value
  // ----------------------------------------------------------------------
  localparam int CFG_DISABLED_BIT = 7;
  localparam int CFG_WINDOW_OPEN_BIT = 6;
  localparam int CFG_SEL_W = 3;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [CFG_SEL_W-1:0] SEL_RESET = 3'h0;

  // ----------------------------------------------------------------------
  // service codes
  // ----------------------------------------------------------------------
  localparam logic [7:0] CODE_FIRST = 8'hAA;
  localparam logic [7:0] CODE_SECOND = 8'h55;

  // gray codes along init -> window -> fault; off hangs beside init
  typedef enum logic [1:0] {
    ST_INIT = 2'h0,
    ST_WINDOW = 2'h1,
    ST_FAULT = 2'h3,
    ST_OFF = 2'h2
  } wwd_state_type;

endpackage

/* File: hdl/wwd_tick.sv */
`timescale 1ns/1ps
`default_nettype none

// millisecond tick from the base clock; halts and restarts when not run
module wwd_tick #(
  parameter int P_MS_CYCLES = wwd_pkg::MS_CYCLES
) (
  input wire logic i_clock, // base clock
  input wire logic i_rst, // async reset, active high
  input wire logic i_run, // count while high
  input wire logic i_restart, // restart the current millisecond
  output logic o_tick // one-cycle pulse per millisecond
);

  typedef struct packed {
    logic [31:0] cnt;
    logic tick;
  } wwd_tick_st_type;

  wwd_tick_st_type q_r;
  wwd_tick_st_type q_nxt;

  always_comb begin
    q_nxt = q_r;
    q_nxt.tick = 1'b0;
    if (!i_run || i_restart) begin
      q_nxt.cnt = 32'h0;
    end else if (q_r.cnt == 32'(P_MS_CYCLES - 1)) begin
      q_nxt.cnt = 32'h0;
      q_nxt.tick = 1'b1;
    end else begin
      q_nxt.cnt = q_r.cnt + 32'h1;
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign o_tick = q_r.tick;

endmodule

`default_nettype wire

/* File: testbench/wwd_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module wwd_checker #(
  parameter int P_MS_CYCLES = 10,
  parameter int P_INIT_MS = 8
) (
  input wire logic i_clock, // clock
  input wire logic i_rst, // reset
  input wire logic i_wr, // write
  input wire logic i_rd, // read
  input wire logic [11:0] i_addr, // address
  input wire logic [7:0] i_wdata, // data
  input wire logic i_test_disable, // test off
  input wire logic i_stop_mode, // stop
  input wire logic i_sleep_mode, // sleep
  input wire logic [7:0] o_rdata, // read data
  input wire logic o_wd_reset_req, // reset request
  input wire logic o_window_open, // open flag
  input wire logic o_wd_disabled // off flag
);
  localparam int T_INIT = P_INIT_MS * P_MS_CYCLES;
  logic act;
  logic svc;
  logic fresh_r;
  int idle_r;
  assign act = !i_test_disable && !i_stop_mode && !i_sleep_mode;
  assign svc = i_wr && (i_addr == 12'h211 || i_addr == 12'h311);
  // active cycles since release with no service write seen yet
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      idle_r <= 0;
      fresh_r <= 1'b1;
    end else begin
      idle_r <= act ? idle_r + 1 : 0;
      fresh_r <= !act || (fresh_r && !svc);
    end
  end
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);
  sequence cfg_rd;
    i_rd && (i_addr == 12'h210 || i_addr == 12'h310);
  endsequence
  sequence bad_wr;
    svc && act && $past(act) && o_window_open
      && i_wdata != 8'hAA && i_wdata != 8'h55;
  endsequence
  init_late_a: assert property (
    fresh_r && act && idle_r == T_INIT + 5 |-> o_wd_reset_req)
    else $error("initial timeout missed");
  init_early_a: assert property (
    $rose(o_wd_reset_req) && fresh_r |-> idle_r >= T_INIT - P_MS_CYCLES)
    else $error("initial timeout too early");
  req_hold_a: assert property (
    o_wd_reset_req |=> o_wd_reset_req) else $error("request dropped");
  off_flag_a: assert property (
    i_test_disable |=> o_wd_disabled) else $error("off flag missing");
  stop_read_a: assert property (
    i_stop_mode && i_rd |-> ##[1:2] o_wd_disabled)
    else $error("stop read flag missing");
  cfg_zero_a: assert property (
    cfg_rd |=> o_rdata[5:3] == 3'h0) else $error("unused bits set");
  cfg_flags_a: assert property (
    cfg_rd |=> o_rdata[7] == $past(o_wd_disabled)
      && o_rdata[6] == $past(o_window_open)) else $error("flags wrong");
  bad_code_a: assert property (
    bad_wr |=> o_wd_reset_req) else $error("wrong code accepted");
  off_ignore_a: assert property (
    svc && i_test_disable && !o_wd_reset_req |=> !o_wd_reset_req)
    else $error("write acted while off");
  lp_closed_a: assert property (
    (i_stop_mode || i_sleep_mode) [*3] |-> !o_window_open)
    else $error("open in low power");
endmodule
bind wwd_top wwd_checker #(.P_MS_CYCLES(P_MS_CYCLES), .P_INIT_MS(P_INIT_MS))
  u_chk (.i_clock(i_clock), .i_rst(i_rst), .i_wr(i_wr), .i_rd(i_rd),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_test_disable(i_test_disable),
  .i_stop_mode(i_stop_mode), .i_sleep_mode(i_sleep_mode),
  .o_rdata(o_rdata), .o_wd_reset_req(o_wd_reset_req),
  .o_window_open(o_window_open), .o_wd_disabled(o_wd_disabled));
`default_nettype wire

/* File: testbench/wwd_mcu.sv */
`timescale 1ns/1ps
`default_nettype none
module wwd_mcu (
  input wire logic i_clock, // clock
  input wire logic i_rst, // reset
  input wire logic [7:0] i_rdata, // read data
  output logic o_wr, // write
  output logic o_rd, // read
  output logic [11:0] o_addr, // address
  output logic [7:0] o_wdata // data
);
  logic [7:0] code_r = 8'hAA;
  initial begin
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_addr = 12'hFFF;
    o_wdata = 8'h00;
  end
  always @(posedge i_rst) code_r = 8'hAA;
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [7:0] d, output logic [7:0] q);
    @(negedge i_clock);
    o_wr = w;
    o_rd = !w;
    o_addr = a;
    o_wdata = d;
    @(negedge i_clock);
    o_wr = 1'b0;
    o_rd = 1'b0;
    // idle bus carries the inverse so no stale value looks valid
    o_addr = ~a;
    o_wdata = ~d;
    @(negedge i_clock);
    q = i_rdata;
  endtask
  task automatic service(output logic [7:0] q);
    xfer(1'b1, 12'h211, code_r, q);
    code_r = ~code_r;
  endtask
  task automatic restart;
    code_r = 8'hAA;
  endtask
endmodule
`default_nettype wire

/* File: testbench/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int MSC = 10;
  logic i_clock, i_rst, i_wr, i_rd, i_test_disable, i_stop_mode;
  logic i_sleep_mode, o_wd_reset_req, o_window_open, o_wd_disabled;
  logic [11:0] i_addr;
  logic [7:0] i_wdata, o_rdata, q;
  int n_fail = 0, comparisons = 0, cyc = 0, t;
  wwd_top #(.P_MS_CYCLES(MSC), .P_INIT_MS(8)) dut (.i_clock(i_clock),
    .i_rst(i_rst), .i_wr(i_wr), .i_rd(i_rd), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_test_disable(i_test_disable),
    .i_stop_mode(i_stop_mode), .i_sleep_mode(i_sleep_mode),
    .o_rdata(o_rdata), .o_wd_reset_req(o_wd_reset_req),
    .o_window_open(o_window_open), .o_wd_disabled(o_wd_disabled));
  wwd_mcu mcu (.i_clock(i_clock), .i_rst(i_rst), .i_rdata(o_rdata),
    .o_wr(i_wr), .o_rd(i_rd), .o_addr(i_addr), .o_wdata(i_wdata));
  initial begin
    i_clock = 1'b0;
    forever #10 i_clock = ~i_clock;
  end
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task summarize;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge i_clock) begin
    cyc++;
    if (cyc == 60000) begin
      n_fail++;
      summarize();
    end
  end
  task rst;
    i_rst = 1'b1;
    repeat (12) @(negedge i_clock);
    i_rst = 1'b0;
  endtask
  task wr(input logic [11:0] a, input logic [7:0] d);
    mcu.xfer(1'b1, a, d, q);
  endtask
  task rd(input logic [11:0] a);
    mcu.xfer(1'b0, a, 8'h00, q);
  endtask
  // bounded poll of the request (sel 1) or the open flag (sel 0)
  task wt(input bit sel, input int lim);
    t = 0;
    while ((sel ? o_wd_reset_req : o_window_open) !== 1'b1 && t < lim) begin
      @(negedge i_clock);
      t++;
    end
  endtask
  initial begin
    i_test_disable = 1'b0;
    i_stop_mode = 1'b0;
    i_sleep_mode = 1'b0;
    rst();
    rd(12'h210);
    chk("cfg", 8'h40, q);
    wr(12'h310, 8'hFF);
    rd(12'h210);
    chk("cfg sel", 8'h47, q);
    rd(12'h2F0);
    chk("unmapped", 8'h00, q);
    wt(1, 200);
    chk("init timeout", 8'h01, 8'(t > 55 && t < 80));
    // let the request stand a while so the checker sees it held
    repeat (8) @(negedge i_clock);
    chk("req held", 8'h01, 8'(o_wd_reset_req));
    rst();
    wr(12'h211, 8'h33);
    chk("bad first", 8'h01, 8'(o_wd_reset_req));
    rst();
    mcu.service(q);
    chk("closed", 8'h00, 8'({o_wd_reset_req, o_window_open}));
    wt(0, 80);
    chk("half", 8'h01, 8'(t > 40));
    rd(12'h310);
    chk("open bit", 8'h40, q);
    mcu.service(q);
    wt(0, 80);
    mcu.service(q);
    chk("served", 8'h00, 8'(o_wd_reset_req));
    wt(0, 80);
    wr(12'h311, 8'hAA);
    chk("repeat code", 8'h01, 8'(o_wd_reset_req));
    rst();
    mcu.service(q);
    mcu.service(q);
    chk("early", 8'h01, 8'(o_wd_reset_req));
    for (int s = 0; s < 8; s++) begin
      rst();
      wr(12'h210, 8'(s));
      mcu.service(q);
      wt(1, 13000);
      chk("timeout", 8'h01, 8'(t > ((10 << s) - 1) * MSC
        && t <= (10 << s) * MSC));
    end
    rst();
    mcu.service(q);
    i_test_disable = 1'b1;
    rd(12'h210);
    chk("off flag", 8'h01, 8'(q[7]));
    wr(12'h211, 8'h33);
    repeat (200) @(negedge i_clock);
    chk("off quiet", 8'h00, 8'(o_wd_reset_req));
    i_test_disable = 1'b0;
    mcu.restart();
    repeat (2) @(negedge i_clock);
    rd(12'h210);
    chk("restart", 8'h40, q);
    mcu.service(q);
    chk("re-init", 8'h00, 8'(o_wd_reset_req));
    for (int m = 0; m < 2; m++) begin
      rst();
      mcu.service(q);
      {i_stop_mode, i_sleep_mode} = 2'(m + 1);
      rd(12'h210);
      repeat (200) @(negedge i_clock);
      chk("asleep", 8'h00, 8'(o_wd_reset_req));
      {i_stop_mode, i_sleep_mode} = 2'h0;
      mcu.restart();
      rd(12'h210);
      chk("stop read", 8'(m == 1), 8'(q[7]));
      mcu.service(q);
      chk("reserved", 8'h00, 8'(o_wd_reset_req));
    end
    summarize();
  end
endmodule
`default_nettype wire
